// ===== inc/arp_defs.vh
// Purpose: Constants shared by the byte-level round primitive datapath.
// Assumes: Operands are 128-bit states with byte S(i,j) at bits 8*(4j+i)+7:8*(4j+i).
// Notes:   Operation codes are presented on req_op_i together with req_valid_i.
`ifndef ARP_DEFS_VH
`define ARP_DEFS_VH

`define ARP_OP_W          4
`define ARP_OP_MIX        4'h0
`define ARP_OP_INV_MIX    4'h1
`define ARP_OP_SHIFT      4'h2
`define ARP_OP_INV_SHIFT  4'h3
`define ARP_OP_SUB        4'h4
`define ARP_OP_INV_SUB    4'h5
`define ARP_OP_ROT_WORD   4'h6
`define ARP_OP_SUB_WORD   4'h7
`define ARP_OP_GF_MUL     4'h8

`define ARP_GF_REDUCE     8'h1b
`define ARP_AFFINE_C      8'h63
`define ARP_INV_AFFINE_C  8'h05
`define ARP_STATE_RST     128'h0
`define ARP_LATENCY       1

`endif

// ===== core/arp_round_primitives.v
// Purpose: Single-cycle datapath for the byte-level AES round primitives.
// Assumes: Requests come from logic on clock_i; one primitive per request.
// Notes:   Substitution tables are formed from the field inverse and the affine map,
//          which gives exactly the standard table contents without stored constants.
`timescale 1ns/1ps
`include "arp_defs.vh"

// Contract
// [RULE_01] Every 128-bit operand is a little-endian state, used in that byte order.
// [RULE_02] Byte S(i,j) sits at bits 8*(4j+i)+7 down to 8*(4j+i).
// [RULE_03] Byte multiply in GF(2^8) reduced modulo x^8+x^4+x^3+x+1.
// [RULE_04] Field addition is bitwise exclusive-OR of the two bytes.
// [RULE_05] Product is carry-less polynomial multiply, then remainder by the field polynomial.
// [RULE_06] Forward column mix: 2*b(r) ^ 3*b(r+1) ^ b(r+2) ^ b(r+3) per column.
// [RULE_07] Inverse column mix: 0e*b(r) ^ 0b*b(r+1) ^ 0d*b(r+2) ^ 09*b(r+3).
// [RULE_08] Forward row shift: output S'(r,j) equals S(r,(j+r) mod 4).
// [RULE_09] Inverse row shift: output S'(r,j) equals S(r,(j-r) mod 4).
// [RULE_10] Forward substitution replaces each byte, high nibble row, low nibble column.
// [RULE_11] Forward table is the standard S-box: 00->63, 01->7c, ff->16.
// [RULE_12] Inverse substitution uses the inverse S-box: 00->52, ff->7d.
// [RULE_13] Word rotation outputs bytes S0,S3,S2,S1: right byte rotation.
// [RULE_14] Word substitution passes each byte through the S-box in place.
// [RULE_15] One primitive per request; result after a fixed latency of one cycle.
module arp_round_primitives (
  input  wire         clock_i,
  input  wire         rst_b_i,
  input  wire         req_valid_i,
  input  wire [3:0]   req_op_i,
  input  wire [127:0] req_data_i,
  output reg          res_valid_o,
  output reg          res_bad_op_o,
  output reg  [127:0] res_data_o
);

  // [RULE_03] Reduce by field polynomial
  // [RULE_05] Shift-and-add carry-less product
  function [7:0] gf_byte_multiply;
    input [7:0] a;
    input [7:0] b;
    integer     k;
    reg   [7:0] acc;
    reg   [7:0] p;
    begin
      acc = 8'h00;
      p   = a;
      for (k = 0; k < 8; k = k + 1) begin
        // [RULE_04] Field addition as exclusive-OR
        if (b[k]) begin
          acc = acc ^ p;
        end
        p = {p[6:0], 1'b0} ^ (p[7] ? `ARP_GF_REDUCE : 8'h00);
      end
      gf_byte_multiply = acc;
    end
  endfunction

  // Field inverse as x^254; zero maps to zero
  function [7:0] gf_inverse;
    input [7:0] x;
    integer     k;
    reg   [7:0] r;
    reg   [7:0] p;
    begin
      r = 8'h01;
      p = x;
      for (k = 1; k < 8; k = k + 1) begin
        p = gf_byte_multiply(p, p);
        r = gf_byte_multiply(r, p);
      end
      gf_inverse = r;
    end
  endfunction

  function [7:0] rotl8;
    input [7:0] v;
    input [2:0] n;
    begin
      rotl8 = (v << n) | (v >> (4'd8 - {1'b0, n}));
    end
  endfunction

  // [RULE_10] Whole byte indexes the table, nibbles as row and column
  // [RULE_11] Standard forward substitution contents
  function [7:0] sbox_fwd;
    input [7:0] x;
    reg   [7:0] q;
    begin
      q = gf_inverse(x);
      sbox_fwd = q ^ rotl8(q, 3'd1) ^ rotl8(q, 3'd2) ^ rotl8(q, 3'd3) ^ rotl8(q, 3'd4) ^ `ARP_AFFINE_C;
    end
  endfunction

  // [RULE_12] Inverse affine map then field inverse
  function [7:0] sbox_inv;
    input [7:0] x;
    begin
      sbox_inv = gf_inverse(rotl8(x, 3'd1) ^ rotl8(x, 3'd3) ^ rotl8(x, 3'd6) ^ `ARP_INV_AFFINE_C);
    end
  endfunction

  // [RULE_02] Byte S(i,j) placement
  function [7:0] st_byte;
    input [127:0] s;
    input integer i;
    input integer j;
    begin
      st_byte = s[8*(4*j+i) +: 8];
    end
  endfunction

  // One output byte of a column times a circulant coefficient row
  function [7:0] mix_byte;
    input [7:0]   c0;
    input [7:0]   c1;
    input [7:0]   c2;
    input [7:0]   c3;
    input [31:0]  col;
    input integer r;
    begin
      mix_byte = gf_byte_multiply(c0, col[8*r +: 8])
               ^ gf_byte_multiply(c1, col[8*((r + 1) % 4) +: 8])
               ^ gf_byte_multiply(c2, col[8*((r + 2) % 4) +: 8])
               ^ gf_byte_multiply(c3, col[8*((r + 3) % 4) +: 8]);
    end
  endfunction

  // Codes above the last primitive are undefined
  function op_is_defined;
    input [3:0] op;
    begin
      op_is_defined = (op <= `ARP_OP_GF_MUL);
    end
  endfunction

  reg [127:0] next_result;
  reg         next_bad;
  reg [127:0] mix_fwd_state;
  reg [127:0] mix_inv_state;
  reg [127:0] shift_fwd_state;
  reg [127:0] shift_inv_state;
  reg [127:0] sub_fwd_state;
  reg [127:0] sub_inv_state;
  reg [127:0] rot_word_state;
  reg [127:0] gf_mul_state;

  // Every primitive is formed in parallel; the op code only picks the one
  // that is registered, so the result path stays a single stage.

  // [RULE_06] Forward column mix
  always @* begin : mix_fwd_blk
    integer c;
    integer r;
    c             = 0;
    r             = 0;
    mix_fwd_state = `ARP_STATE_RST;
    for (c = 0; c < 4; c = c + 1) begin
      for (r = 0; r < 4; r = r + 1) begin
        mix_fwd_state[8*(4*c+r) +: 8] = mix_byte(8'h02, 8'h03, 8'h01, 8'h01, req_data_i[32*c +: 32], r);
      end
    end
  end

  // [RULE_07] Inverse column mix
  always @* begin : mix_inv_blk
    integer c;
    integer r;
    c             = 0;
    r             = 0;
    mix_inv_state = `ARP_STATE_RST;
    for (c = 0; c < 4; c = c + 1) begin
      for (r = 0; r < 4; r = r + 1) begin
        mix_inv_state[8*(4*c+r) +: 8] = mix_byte(8'h0e, 8'h0b, 8'h0d, 8'h09, req_data_i[32*c +: 32], r);
      end
    end
  end

  // [RULE_08] Row r rotated left by r
  always @* begin : shift_fwd_blk
    integer c;
    integer r;
    c               = 0;
    r               = 0;
    shift_fwd_state = `ARP_STATE_RST;
    for (c = 0; c < 4; c = c + 1) begin
      for (r = 0; r < 4; r = r + 1) begin
        shift_fwd_state[8*(4*c+r) +: 8] = st_byte(req_data_i, r, (c + r) % 4);
      end
    end
  end

  // [RULE_09] Row r rotated right by r
  always @* begin : shift_inv_blk
    integer c;
    integer r;
    c               = 0;
    r               = 0;
    shift_inv_state = `ARP_STATE_RST;
    for (c = 0; c < 4; c = c + 1) begin
      for (r = 0; r < 4; r = r + 1) begin
        shift_inv_state[8*(4*c+r) +: 8] = st_byte(req_data_i, r, (c + 4 - r) % 4);
      end
    end
  end

  // [RULE_10] Each byte looks up the forward table
  // Sixteen table instances side by side: area traded for one-cycle latency
  always @* begin : sub_fwd_blk
    integer n;
    n             = 0;
    sub_fwd_state = `ARP_STATE_RST;
    for (n = 0; n < 16; n = n + 1) begin
      sub_fwd_state[8*n +: 8] = sbox_fwd(req_data_i[8*n +: 8]);
    end
  end

  // [RULE_12] Each byte looks up the inverse table
  always @* begin : sub_inv_blk
    integer n;
    n             = 0;
    sub_inv_state = `ARP_STATE_RST;
    for (n = 0; n < 16; n = n + 1) begin
      sub_inv_state[8*n +: 8] = sbox_inv(req_data_i[8*n +: 8]);
    end
  end

  // [RULE_13] Right byte rotation of each word
  always @* begin : rot_word_blk
    integer    n;
    reg [31:0] w;
    n              = 0;
    w              = 32'h0;
    rot_word_state = `ARP_STATE_RST;
    for (n = 0; n < 4; n = n + 1) begin
      w                          = req_data_i[32*n +: 32];
      rot_word_state[32*n +: 32] = {w[7:0], w[31:8]};
    end
  end

  // [RULE_05] Product of the two low operand bytes
  always @* begin
    gf_mul_state      = `ARP_STATE_RST;
    gf_mul_state[7:0] = gf_byte_multiply(req_data_i[7:0], req_data_i[15:8]);
  end

  // [RULE_01] Little-endian state throughout
  // [RULE_15] Op code selects one primitive
  always @* begin
    next_result = `ARP_STATE_RST;
    next_bad    = ~op_is_defined(req_op_i);
    case (req_op_i)
      `ARP_OP_MIX: begin
        next_result = mix_fwd_state;
      end
      `ARP_OP_INV_MIX: begin
        next_result = mix_inv_state;
      end
      `ARP_OP_SHIFT: begin
        next_result = shift_fwd_state;
      end
      `ARP_OP_INV_SHIFT: begin
        next_result = shift_inv_state;
      end
      `ARP_OP_SUB: begin
        next_result = sub_fwd_state;
      end
      `ARP_OP_INV_SUB: begin
        next_result = sub_inv_state;
      end
      `ARP_OP_ROT_WORD: begin
        next_result = rot_word_state;
      end
      // [RULE_14] Word substitution keeps byte positions
      `ARP_OP_SUB_WORD: begin
        next_result = sub_fwd_state;
      end
      `ARP_OP_GF_MUL: begin
        next_result = gf_mul_state;
      end
      // Undefined codes answer with zero data and the flag
      default: begin
        next_result = `ARP_STATE_RST;
      end
    endcase
  end

  // [RULE_15] Fixed one-cycle latency
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      res_valid_o  <= 1'b0;
      res_bad_op_o <= 1'b0;
      res_data_o   <= `ARP_STATE_RST;
    end else begin
      res_valid_o <= req_valid_i;
      if (req_valid_i) begin
        res_bad_op_o <= next_bad;
        res_data_o   <= next_result;
      end
    end
  end

endmodule // arp_round_primitives

// ===== verification/arp_round_primitives_asserts.sv
// Purpose: Port checks for the round primitive datapath.
// Assumes: One-cycle result latency.
// Notes:   Bound from tb.
`timescale 1ns/1ps
`include "arp_defs.vh"
module arp_chk (
  input logic         clock_i,
  input logic         rst_b_i,
  input logic         req_valid_i,
  input logic [3:0]   req_op_i,
  input logic [127:0] req_data_i,
  input logic         res_valid_o,
  input logic         res_bad_op_o,
  input logic [127:0] res_data_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wire v   = req_valid_i;
  wire rot = v && req_op_i == `ARP_OP_ROT_WORD;
  wire shf = v && req_op_i == `ARP_OP_SHIFT;
  wire ish = v && req_op_i == `ARP_OP_INV_SHIFT;
  wire mul = v && req_op_i == `ARP_OP_GF_MUL;
  wire bad = v && req_op_i > 4'h8;
  a_res_latency: assert property (v |=> res_valid_o) else $error("no result");
  a_no_spurious: assert property (!v |=> !res_valid_o && $stable(res_data_o)) else $error("spurious");
  a_bad_op: assert property (bad |=> res_bad_op_o && res_data_o == 128'h0) else $error("bad op");
  a_good_op: assert property (v && !bad |=> !res_bad_op_o) else $error("good op flagged");
  a_rot_word: assert property (rot |=> res_data_o[31:0] == {$past(req_data_i[7:0]), $past(req_data_i[31:8])})
    else $error("rotate");
  a_shift_row: assert property (shf |=> res_data_o[15:8] == $past(req_data_i[47:40])
    && res_data_o[23:16] == $past(req_data_i[87:80])) else $error("shift");
  a_inv_shift: assert property (ish |=> res_data_o[15:8] == $past(req_data_i[111:104])) else $error("inv shift");
  a_gf_upper: assert property (mul |=> res_data_o[127:8] == 120'h0) else $error("multiply upper");
  c_rot: cover property (rot);
  c_bad: cover property (bad);
  c_mul: cover property (mul);
endmodule // arp_chk

// ===== verification/arp_host_model.sv
// Purpose: Requesting datapath in front of the primitives.
// Assumes: Result is read in the cycle after the request is taken.
// Notes:   Operand lines are inverted once released.
`timescale 1ns/1ps
module arp_host_model (
  input  logic         clock_i,
  output logic         req_valid_o,
  output logic [3:0]   req_op_o,
  output logic [127:0] req_data_o,
  input  logic         res_valid_i,
  input  logic         res_bad_op_i,
  input  logic [127:0] res_data_i
);
  initial begin
    req_valid_o = 1'b0;
    req_op_o = 4'h0;
    req_data_o = 128'h0;
  end
  task send(input [3:0] op, input [127:0] d, output [127:0] r, output bad, output vld);
    @(posedge clock_i);
    req_valid_o <= 1'b1;
    req_op_o <= op;
    req_data_o <= d;
    @(posedge clock_i);
    req_valid_o <= 1'b0;
    req_op_o <= ~op;
    req_data_o <= ~d;
    @(negedge clock_i);
    r = res_data_i;
    bad = res_bad_op_i;
    vld = res_valid_i;
  endtask
endmodule // arp_host_model

// ===== verification/tb.sv
// Purpose: Directed checks of every primitive.
// Assumes: One-cycle latency.
// Notes:   Expected values are worked by hand.
`timescale 1ns/1ps
`include "arp_defs.vh"
module tb;
  logic clock_i, rst_b_i, req_valid_i, res_valid_o, res_bad_op_o, bad, vld;
  logic [3:0] req_op_i;
  logic [127:0] req_data_i, res_data_o, r, e, f;
  int errors, n_checks;
  arp_round_primitives u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_op_i(req_op_i),
    .req_data_i(req_data_i), .res_valid_o(res_valid_o), .res_bad_op_o(res_bad_op_o), .res_data_o(res_data_o));
  arp_host_model u_host (.clock_i(clock_i), .req_valid_o(req_valid_i), .req_op_o(req_op_i), .req_data_o(req_data_i),
    .res_valid_i(res_valid_o), .res_bad_op_i(res_bad_op_o), .res_data_i(res_data_o));
  task chk(input string nm, input [127:0] seen, input [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task run(input string nm, input [3:0] op, input [127:0] d, input [127:0] exp);
    u_host.send(op, d, r, bad, vld);
    chk({nm, " flags"}, {vld, bad}, {1'b1, op > 4'h8});
    chk(nm, r, exp);
  endtask
  task t_gf;
    run("gf mul", `ARP_OP_GF_MUL, {8'h83, 8'h57}, 128'hc1);
    run("gf reduce", `ARP_OP_GF_MUL, {8'h02, 8'h80}, 128'h1b);
    $display("gf done");
  endtask
  task t_mix;
    e = {32'h0, 32'h101, 32'h80, 32'h1};
    run("mix", `ARP_OP_MIX, e, {32'h0, 32'h02000301, 32'h9b80801b, 32'h03010102});
    run("mix round trip", `ARP_OP_INV_MIX, r, e);
    run("inv mix", `ARP_OP_INV_MIX, 128'h1, 128'h0b0d090e);
    $display("mix done");
  endtask
  task t_sub;
    e = {{12{8'h63}}, 32'h63167c63};
    run("sub", `ARP_OP_SUB, 32'h00ff0100, e);
    run("sub word", `ARP_OP_SUB_WORD, 32'h00ff0100, e);
    run("sub round trip", `ARP_OP_INV_SUB, r, 128'h00ff0100);
    run("inv sub", `ARP_OP_INV_SUB, 32'h00ff0100, {{12{8'h52}}, 32'h527d0952});
    $display("sub done");
  endtask
  task t_word;
    run("rot word", `ARP_OP_ROT_WORD, {4{32'h33221100}}, {4{32'h00332211}});
    $display("word done");
  endtask
  task t_shift;
    e = 128'h0b06010c07020d08030e09040f0a0500;
    f = 128'h0306090c0f0205080b0e0104070a0d00;
    run("shift", `ARP_OP_SHIFT, 128'h0f0e0d0c0b0a09080706050403020100, e);
    run("inv shift", `ARP_OP_INV_SHIFT, 128'h0f0e0d0c0b0a09080706050403020100, f);
    $display("shift done");
  endtask
  task t_reset;
    @(posedge clock_i);
    rst_b_i <= 1'b0;
    @(negedge clock_i);
    chk("mid reset flags", {res_valid_o, res_bad_op_o}, 2'b00);
    chk("mid reset data", res_data_o, 128'h0);
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    e = 128'h0c0f0e0d080b0a090407060500030201;
    run("after reset", `ARP_OP_ROT_WORD, 128'h0f0e0d0c0b0a09080706050403020100, e);
    $display("reset done");
  endtask
  task t_bad;
    for (int op = 9; op < 16; op++) run("bad op", 4'(op), ~128'h0, 128'h0);
    $display("bad done");
  endtask
  task finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  initial begin
    #5000;
    errors++;
    finish_test;
  end
  initial begin
    rst_b_i = 1'b0;
    repeat (12) @(posedge clock_i);
    chk("reset flags", {res_valid_o, res_bad_op_o}, 2'b00);
    chk("reset data", res_data_o, 128'h0);
    rst_b_i <= 1'b1;
    t_gf;
    t_mix;
    t_sub;
    t_word;
    t_shift;
    t_reset;
    t_bad;
    finish_test;
  end
endmodule // tb
bind arp_round_primitives arp_chk u_chk (.clock_i(clock_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i),
  .req_op_i(req_op_i), .req_data_i(req_data_i), .res_valid_o(res_valid_o), .res_bad_op_o(res_bad_op_o),
  .res_data_o(res_data_o));
